// >>> verilog/smc_top.sv
// Supply monitor control: registers, flag, interrupt and reset request
`timescale 1ns/1ns
// Notes on behaviour
// - Monitor-caused reset keeps threshold register; other resets clear it.
// - Changing level while enabled gives undefined level; disable first.
// - Reset response: reset held while supply below threshold, then released.
// - Interrupt response: low-supply interrupt raised when supply drops.
// - With mask clear, an interrupt may follow enable at once.
// - Selecting reset mode with adequate supply does not assert reset.
// - Any reset sets the interrupt mask bit.
// - Monitor reset cause flag is bit 0 of the cause register.
// - Control: enable bit 7, mode bit 1, read-only flag bit 0.
// - Flag is one while supply below threshold and monitor enabled.
// - Flag drives interrupt only when enabled and in interrupt mode.
// - Monitor-caused reset keeps control register; other resets clear it.
module smc_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [15:0] wb_adr_i,
   input  wire logic [7:0]  wb_dat_i,
   input  wire logic        wb_sel_i,
   output logic      [7:0]  wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        cmp_below_i,
   output logic             cmp_en_o,
   output logic      [3:0]  level_code_o,
   output logic             low_supply_irq_o,
   output logic             monitor_reset_o
);
   // ***********************************************************
   // State
   // ***********************************************************
   logic       below_sync;
   logic       enable_q;
   logic       mode_q;
   logic [3:0] level_q;
   logic       cause_q;
   logic       mask_q;
   logic       pend_q;
   logic       flag;
   logic       req;
   logic       wr;
   logic       rd;
   logic       mon_rst_q;
   logic       keep_q;
   logic       keep;
   logic       wipe;

   smc_sync u_sync (
      .clk_i   (clk_i),
      .rst_i   (wipe),
      .async_i (cmp_below_i),
      .sync_o  (below_sync)
   );

   assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr   = req && wb_we_i && wb_sel_i;
   assign rd   = req && !wb_we_i;
   assign flag = enable_q && below_sync;
   assign keep = mon_rst_q || keep_q;

   // ***********************************************************
   // Reset source: a reset met while the monitor asks for one
   // ***********************************************************
   // An unknown request flag falls through to a full clear at power-up
   always_comb begin
      wipe = rst_i;
      if (rst_i && keep) begin
         wipe = 1'h0;
      end
   end

   // Remembers the monitor as cause for as long as the reset lasts
   always_ff @(posedge clk_i) begin
      if (wipe) begin
         keep_q <= 1'h0;
      end else begin
         keep_q <= rst_i;
      end
   end

   function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
      hit = (a == o);
   endfunction

   // ***********************************************************
   // Control register; kept across a monitor-caused reset
   // ***********************************************************
   always_ff @(posedge clk_i) begin
      if (wipe) begin
         enable_q <= smc_pkg::CTRL_RST[smc_pkg::CTRL_EN_BIT];
         mode_q   <= smc_pkg::CTRL_RST[smc_pkg::CTRL_MODE_BIT];
      end else if (wr && hit(wb_adr_i, smc_pkg::CTRL_OFS)) begin
         enable_q <= wb_dat_i[smc_pkg::CTRL_EN_BIT];
         mode_q   <= wb_dat_i[smc_pkg::CTRL_MODE_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (wipe) begin
         level_q <= smc_pkg::THRESH_RST[3:0];
      end else if (wr && hit(wb_adr_i, smc_pkg::THRESH_OFS)) begin
         level_q <= wb_dat_i[3:0];
      end
   end

   // ***********************************************************
   // Reset request and cause
   // ***********************************************************
   always_ff @(posedge clk_i) begin
      if (wipe) begin
         mon_rst_q <= 1'h0;
      end else begin
         mon_rst_q <= enable_q && mode_q && below_sync;
      end
   end

   always_ff @(posedge clk_i) begin
      if (wipe) begin
         cause_q <= 1'h0;
      end else if (mon_rst_q) begin
         cause_q <= 1'h1;
      end else if (rd && hit(wb_adr_i, smc_pkg::CAUSE_OFS)) begin
         cause_q <= 1'h0;
      end
   end

   // ***********************************************************
   // Interrupt pending and mask
   // ***********************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= smc_pkg::MASK_RST;
      end else if (wr && hit(wb_adr_i, smc_pkg::IRQ_OFS)) begin
         mask_q <= wb_dat_i[smc_pkg::IRQ_MASK_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 1'h0;
      end else if (flag && !mode_q) begin
         pend_q <= 1'h1;
      end else if (wr && hit(wb_adr_i, smc_pkg::IRQ_OFS)
                   && !wb_dat_i[smc_pkg::IRQ_PEND_BIT]) begin
         pend_q <= 1'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_supply_irq_o <= 1'h0;
      end else begin
         low_supply_irq_o <= flag && !mode_q && !mask_q;
      end
   end

   // ***********************************************************
   // Analogue side outputs
   // ***********************************************************
   always_ff @(posedge clk_i) begin
      if (wipe) begin
         cmp_en_o     <= 1'h0;
         level_code_o <= 4'h0;
      end else begin
         cmp_en_o     <= enable_q;
         level_code_o <= level_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (wipe) begin
         monitor_reset_o <= 1'h0;
      end else begin
         monitor_reset_o <= enable_q && mode_q && below_sync;
      end
   end

   // ***********************************************************
   // Bus slave
   // ***********************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'h0;
         wb_dat_o <= 8'h00;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= 8'h00;
         if (rd) begin
            if (hit(wb_adr_i, smc_pkg::CTRL_OFS)) begin
               wb_dat_o <= {enable_q, 5'h00, mode_q, flag};
            end else if (hit(wb_adr_i, smc_pkg::THRESH_OFS)) begin
               wb_dat_o <= {4'h0, level_q};
            end else if (hit(wb_adr_i, smc_pkg::CAUSE_OFS)) begin
               wb_dat_o <= {7'h00, cause_q};
            end else if (hit(wb_adr_i, smc_pkg::IRQ_OFS)) begin
               wb_dat_o <= {6'h00, mask_q, pend_q};
            end
         end
      end
   end

   // ***********************************************************
   // Checks
   // ***********************************************************
   sequence s_low_rm;
      enable_q && mode_q && below_sync;
   endsequence

   a_reset_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      s_low_rm |=> monitor_reset_o)
      else $error("reset not raised on low supply");
   a_reset_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      !below_sync |=> !monitor_reset_o)
      else $error("reset raised with adequate supply");
   a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      low_supply_irq_o |-> $past(enable_q) && !$past(mode_q))
      else $error("interrupt outside interrupt mode");
   a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
      (flag && !mode_q && !mask_q) |=> low_supply_irq_o)
      else $error("interrupt missing");
   a_flag_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && hit(wb_adr_i, smc_pkg::CTRL_OFS) && !enable_q)
      |=> !wb_dat_o[smc_pkg::CTRL_FLAG_BIT])
      else $error("flag set while disabled");
   a_cause_set: assert property (@(posedge clk_i) disable iff (rst_i)
      mon_rst_q |=> cause_q)
      else $error("cause flag not set");
   a_mask_reset: assert property (@(posedge clk_i)
      rst_i |=> mask_q)
      else $error("mask not set by reset");
   a_level_keep: assert property (@(posedge clk_i)
      (rst_i && mon_rst_q) |=> $stable(level_q))
      else $error("level lost on monitor reset");
   a_cmp_en: assert property (@(posedge clk_i) disable iff (rst_i)
      enable_q |=> cmp_en_o)
      else $error("comparator enable lags");
endmodule

// >>> verilog/smc_pkg.sv
// Package: register map, field layout and reset values of the supply monitor
package smc_pkg;
   // ***********************************************************
   // Register offsets (byte addresses on the bus)
   // ***********************************************************
   localparam logic [15:0] CTRL_OFS      = 16'hff50;
   localparam logic [15:0] THRESH_OFS    = 16'hff51;
   localparam logic [15:0] CAUSE_OFS     = 16'hff52;
   localparam logic [15:0] IRQ_OFS       = 16'hff53;
   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int          CTRL_EN_BIT   = 7;
   localparam int          CTRL_MODE_BIT = 1;
   localparam int          CTRL_FLAG_BIT = 0;
   localparam int          CAUSE_MON_BIT = 0;
   localparam int          IRQ_PEND_BIT  = 0;
   localparam int          IRQ_MASK_BIT  = 1;
   localparam int          LEVEL_W       = 4;
   localparam logic [3:0]  LEVEL_MAX     = 4'h9;
   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [7:0]  THRESH_RST    = 8'h00;
   localparam logic        MASK_RST      = 1'h1;
endpackage

// >>> verilog/smc_sync.sv
// Two-stage synchroniser for the comparator output
`timescale 1ns/1ns
module smc_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 1'h0;
         sync_o <= 1'h0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// >>> verification/smc_cmp_model.sv
// Behavioural supply comparator and threshold ladder
`timescale 1ns/1ns
module smc_cmp_model (
   input  wire logic       clk_i,
   input  wire logic       cmp_en_i,
   input  wire logic [3:0] level_code_i,
   input  wire logic [3:0] supply_rank_i,
   output logic            cmp_below_o
);
   // Rank r: supply lies under the thresholds of codes below r
   initial cmp_below_o = 1'b0;
   // Output means nothing while off, so it toggles every cycle
   always @(posedge clk_i) begin
      if (cmp_en_i) begin
         cmp_below_o <= (level_code_i < supply_rank_i);
      end else begin
         cmp_below_o <= ~cmp_below_o;
      end
   end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the supply monitor control block
`timescale 1ns/1ns
module tb;
   localparam logic [15:0] CT = smc_pkg::CTRL_OFS;
   localparam logic [15:0] TH = smc_pkg::THRESH_OFS;
   localparam logic [15:0] CA = smc_pkg::CAUSE_OFS;
   localparam logic [15:0] IQ = smc_pkg::IRQ_OFS;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic        wb_sel = 1'b1;
   logic [15:0] wb_adr = 16'h0000;
   logic [7:0]  wb_dat = 8'h00;
   logic [7:0]  wb_dat_o;
   logic        wb_ack;
   logic        below;
   logic        cmp_en;
   logic [3:0]  level;
   logic        irq;
   logic        mon_rst;
   logic [3:0]  rank = 4'h0;
   logic [7:0]  rd;
   int          num_errors = 0;
   int          comparisons = 0;
   always #2 clk_i = ~clk_i;
   smc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack), .cmp_below_i(below), .cmp_en_o(cmp_en),
      .level_code_o(level), .low_supply_irq_o(irq),
      .monitor_reset_o(mon_rst));
   smc_cmp_model cmp_u (.clk_i(clk_i), .cmp_en_i(cmp_en),
      .level_code_i(level), .supply_rank_i(rank), .cmp_below_o(below));
   // ***********************************************************
   // Bus and compare helpers
   // ***********************************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
      int n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1) num_errors++;
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rc(input logic [15:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      check(rd, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wait_rst(input logic v);
      int n = 0;
      while (mon_rst !== v && n < 16) begin
         @(posedge clk_i);
         n++;
      end
      check({7'h00, mon_rst}, {7'h00, v});
   endtask
   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic t_reset_vals;
      rc(CT, 8'h00);
      rc(TH, 8'h00);
      rc(IQ, 8'h02);
      rc(CA, 8'h00);
      rc(16'hff54, 8'h00);
   endtask
   task automatic t_level;
      wr(TH, 8'h09);
      rc(TH, 8'h09);
      wb_sel <= 1'b0;
      wr(TH, 8'h03);
      wb_sel <= 1'b1;
      rc(TH, 8'h09);
      check({4'h0, level}, 8'h09);
   endtask
   task automatic t_irq_mode;
      wr(IQ, 8'h02);
      wr(CT, 8'h80);
      idle(6);
      check({7'h00, cmp_en}, 8'h01);
      rc(CT, 8'h80);
      rank <= 4'ha;
      idle(6);
      rc(CT, 8'h81);
      check({7'h00, irq}, 8'h00);
      wr(IQ, 8'h00);
      idle(2);
      check({7'h00, irq}, 8'h01);
      rc(IQ, 8'h01);
      rank <= 4'h0;
      idle(6);
      check({7'h00, irq}, 8'h00);
      rank <= 4'ha;
      wr(CT, 8'h00);
      idle(6);
      check({7'h00, irq}, 8'h00);
      rc(CT, 8'h00);
   endtask
   task automatic t_rst_mode;
      rank <= 4'h0;
      wr(IQ, 8'h02);
      wr(CT, 8'h80);
      idle(6);
      rc(CT, 8'h80);
      wr(CT, 8'h82);
      idle(6);
      check({7'h00, mon_rst}, 8'h00);
      rank <= 4'ha;
      wait_rst(1'b1);
      check({7'h00, irq}, 8'h00);
      rst_i <= 1'b1;
      rank <= 4'h0;
      idle(3);
      rst_i <= 1'b0;
      wait_rst(1'b0);
      rc(TH, 8'h09);
      rc(CT, 8'h82);
      rc(CA, 8'h01);
      rc(CA, 8'h00);
      rc(IQ, 8'h02);
      wr(CT, 8'h02);
      wr(CT, 8'h00);
      rank <= 4'ha;
      idle(6);
      check({7'h00, mon_rst}, 8'h00);
   endtask
   task automatic t_ext_reset;
      wr(CT, 8'h80);
      rst_i <= 1'b1;
      idle(2);
      rst_i <= 1'b0;
      rc(TH, 8'h00);
      rc(CT, 8'h00);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #40000;
      num_errors++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset_vals();
      t_level();
      t_irq_mode();
      t_rst_mode();
      t_ext_reset();
      give_verdict();
   end
endmodule
